/* rtl/ccm_pkg.sv */
// package: command codes, field layout and reset values of the conference/meter register bank
package ccm_pkg;
  localparam logic [7:0] CCM_RW_BIT_MASK   = 8'h80;
  localparam int         CCM_RW_BIT        = 7;
  localparam logic [6:0] CCM_CODE_B_TX     = 7'h28;
  localparam logic [6:0] CCM_CODE_B_RX     = 7'h29;
  localparam logic [6:0] CCM_CODE_C_TX     = 7'h2A;
  localparam logic [6:0] CCM_CODE_C_RX     = 7'h2B;
  localparam logic [6:0] CCM_CODE_D_TX     = 7'h2C;
  localparam logic [6:0] CCM_CODE_D_RX     = 7'h2D;
  localparam logic [6:0] CCM_CODE_PER_LO   = 7'h2E;
  localparam logic [6:0] CCM_CODE_CTRL     = 7'h2F;
  localparam logic [6:0] CCM_CODE_RES_LO   = 7'h30;
  localparam logic [6:0] CCM_CODE_RES_HI   = 7'h31;
  localparam logic [6:0] CCM_CODE_FLAG_LEN = 7'h32;
  // control register bit positions
  localparam int         CCM_CTRL_ONCE     = 7;
  localparam int         CCM_CTRL_EN       = 6;
  localparam int         CCM_CTRL_CS_HI    = 5;
  localparam int         CCM_CTRL_CS_LO    = 4;
  localparam int         CCM_CTRL_PER_HI   = 2;
  localparam int         CCM_PER_W         = 11;
  localparam int         CCM_ACC_W         = 27;
  localparam logic [7:0]  CCM_BYTE_RST     = 8'h00;
  localparam logic [10:0] CCM_PER_RST      = 11'h000;
  localparam logic [15:0] CCM_RES_RST      = 16'h0000;
  localparam logic [15:0] CCM_RES_MAX      = 16'hFFFF;
  localparam logic [1:0]  CCM_CS_RST       = 2'h0;
  localparam logic [10:0] CCM_PER_STEP     = 11'h001;

  typedef struct packed {
    logic       highway_sel;
    logic [6:0] slot;
  } ccm_slot_t;

  localparam ccm_slot_t CCM_SLOT_RST = '{highway_sel: 1'b0, slot: 7'h00};

  typedef struct packed {
    ccm_slot_t party_b_tx;
    ccm_slot_t party_b_rx;
    ccm_slot_t party_c_tx;
    ccm_slot_t party_c_rx;
    ccm_slot_t party_d_tx;
    ccm_slot_t party_d_rx;
  } ccm_conf_t;

  localparam ccm_conf_t CCM_CONF_RST = '{default: CCM_SLOT_RST};

  typedef struct packed {
    logic                 single_shot;
    logic                 enable;
    logic [1:0]           channel_select;
    logic [CCM_PER_W-1:0] period_count;
  } ccm_meter_ctl_t;

  localparam ccm_meter_ctl_t CCM_METER_CTL_RST = '{
    single_shot: 1'b0, enable: 1'b0, channel_select: CCM_CS_RST, period_count: CCM_PER_RST};

  typedef enum logic [1:0] {
    CCM_M_IDLE,
    CCM_M_RUN,
    CCM_M_HOLD
  } ccm_meter_state_t;
endpackage

/* rtl/ccm_regs.sv */
// conference slot, level meter and caller-id flag length register bank
//
// How it works
// - command byte bit 7 selects write(1)/read(0); party-B transmit is 28H/A8H
// - party-B transmit bit 7 routes onto transmit highway one (0) or two (1)
// - every conference slot field is bits 6..0, values 0 to 127
// - party-B receive at 29H: bit 7 receive highway, bits 6..0 slot
// - parties C and D receive registers at 2BH and 2DH, same layout
// - parties C and D transmit registers at 2AH and 2CH, same layout
// - reset leaves all highway selects and slot fields at zero
// - meter period is 11 bits: low byte at 2EH, bits 10..8 at 2FH[2:0]
// - nonzero period N integrates N frames of 125 us, up to 255.875 ms
// - period zero passes the selected sample straight to the result
// - single-shot bit 7 of 2FH: run one period, restart needs enable 0 to 1
// - single-shot cleared: periods repeat continuously while enabled
// - bit 6 of 2FH starts metering when 1, stops when 0, resets to 0
// - bits 5..4 of 2FH select channel 1 to 4, reset 00
// - result low byte read at 30H, high at 31H, read only, reset zero
// - flag length register at 32H, 0 to 255 one-bits, reset zero
`timescale 1ns/1ps
module ccm_regs
  import ccm_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 cmd_valid_in,
  input  wire logic [7:0]           cmd_byte_in,
  input  wire logic [7:0]           cmd_wdata_in,
  input  wire logic                 frame_strobe_in,
  input  wire logic [3:0][15:0]     pcm_sample_in,
  output logic                      rd_valid_out,
  output logic [7:0]                rd_data_out,
  output ccm_conf_t                 conf_out,
  output ccm_meter_ctl_t            meter_ctl_out,
  output logic [15:0]               meter_result_out,
  output logic                      meter_busy_out,
  output logic [7:0]                callerid_flag_bit_count_out
);

  ccm_slot_t        slot_b_tx,   slot_b_rx;
  ccm_slot_t        slot_c_tx,   slot_c_rx;
  ccm_slot_t        slot_d_tx,   slot_d_rx;
  ccm_meter_ctl_t   ctl_r,       ctl_nxt;
  logic             busy_r,      busy_nxt;
  logic [7:0]       flag_len_r,  flag_len_nxt;
  logic             rd_valid_r,  rd_valid_nxt;
  logic [7:0]       rd_data_r,   rd_data_nxt;
  ccm_meter_state_t mstate_r,    mstate_nxt;
  logic [CCM_ACC_W-1:0] acc_r,   acc_nxt;
  logic [CCM_PER_W-1:0] cnt_r,   cnt_nxt;
  logic [15:0]      result_r,    result_nxt;

  logic             is_write;
  logic             wr_en;
  logic [6:0]       code;
  logic [15:0]      sel_sample;
  logic [15:0]      sel_mag;
  logic [CCM_ACC_W-1:0] acc_sum;

  assign is_write = cmd_byte_in[CCM_RW_BIT];
  assign code     = cmd_byte_in[6:0];
  assign wr_en    = cmd_valid_in && is_write;

  // --- conference slot registers ---
  // each register decodes its own write code, so all six share one tested body
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_B_TX)
  ) u_party_b_tx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_b_tx)
  );
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_B_RX)
  ) u_party_b_rx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_b_rx)
  );
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_C_TX)
  ) u_party_c_tx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_c_tx)
  );
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_C_RX)
  ) u_party_c_rx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_c_rx)
  );
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_D_TX)
  ) u_party_d_tx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_d_tx)
  );
  ccm_slot_reg #(
    .WR_CODE (CCM_CODE_D_RX)
  ) u_party_d_rx (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_valid_in (wr_en),
    .wr_code_in  (code),
    .wr_data_in  (cmd_wdata_in),
    .slot_out    (slot_d_rx)
  );

  // --- host command decode and register writes ---
  always_comb begin
    ctl_nxt      = ctl_r;
    flag_len_nxt = flag_len_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt  = rd_data_r;
    if (cmd_valid_in && is_write) begin
      case (code)
        CCM_CODE_B_TX, CCM_CODE_B_RX, CCM_CODE_C_TX,
        CCM_CODE_C_RX, CCM_CODE_D_TX, CCM_CODE_D_RX: ;  // slot registers decode these
        CCM_CODE_PER_LO:   ctl_nxt.period_count[7:0] = cmd_wdata_in;
        CCM_CODE_CTRL: begin
          ctl_nxt.single_shot    = cmd_wdata_in[CCM_CTRL_ONCE];
          ctl_nxt.enable         = cmd_wdata_in[CCM_CTRL_EN];
          ctl_nxt.channel_select = cmd_wdata_in[CCM_CTRL_CS_HI:CCM_CTRL_CS_LO];
          ctl_nxt.period_count[CCM_PER_W-1:8] = cmd_wdata_in[CCM_CTRL_PER_HI:0];
        end
        CCM_CODE_FLAG_LEN: flag_len_nxt = cmd_wdata_in;
        default: ;  // result registers and unmapped codes take no write
      endcase
    end
    if (cmd_valid_in && !is_write) begin
      rd_valid_nxt = 1'b1;
      case (code)
        CCM_CODE_B_TX:     rd_data_nxt = slot_b_tx;
        CCM_CODE_B_RX:     rd_data_nxt = slot_b_rx;
        CCM_CODE_C_TX:     rd_data_nxt = slot_c_tx;
        CCM_CODE_C_RX:     rd_data_nxt = slot_c_rx;
        CCM_CODE_D_TX:     rd_data_nxt = slot_d_tx;
        CCM_CODE_D_RX:     rd_data_nxt = slot_d_rx;
        CCM_CODE_PER_LO:   rd_data_nxt = ctl_r.period_count[7:0];
        CCM_CODE_CTRL:     rd_data_nxt = {ctl_r.single_shot, ctl_r.enable,
                                          ctl_r.channel_select, 1'b0,
                                          ctl_r.period_count[CCM_PER_W-1:8]};
        CCM_CODE_RES_LO:   rd_data_nxt = result_r[7:0];
        CCM_CODE_RES_HI:   rd_data_nxt = result_r[15:8];
        CCM_CODE_FLAG_LEN: rd_data_nxt = flag_len_r;
        default:           rd_data_nxt = CCM_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r      <= CCM_METER_CTL_RST;
      flag_len_r <= CCM_BYTE_RST;
      rd_valid_r <= 1'b0;
      rd_data_r  <= CCM_BYTE_RST;
    end else begin
      ctl_r      <= ctl_nxt;
      flag_len_r <= flag_len_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // --- level meter: magnitude integrator over frames ---
  assign sel_sample = pcm_sample_in[ctl_r.channel_select];
  assign sel_mag    = sel_sample[15] ? 16'(~sel_sample + 16'h0001) : sel_sample;
  assign acc_sum    = acc_r + CCM_ACC_W'(sel_mag);

  always_comb begin
    mstate_nxt = mstate_r;
    acc_nxt    = acc_r;
    cnt_nxt    = cnt_r;
    result_nxt = result_r;
    case (mstate_r)
      CCM_M_IDLE: begin
        acc_nxt = '0;
        cnt_nxt = '0;
        if (ctl_r.enable) begin
          mstate_nxt = CCM_M_RUN;
        end
      end
      CCM_M_RUN: begin
        if (!ctl_r.enable) begin
          mstate_nxt = CCM_M_IDLE;
        end else if (frame_strobe_in) begin
          if (ctl_r.period_count == CCM_PER_RST) begin
            result_nxt = sel_sample;
          end else if (cnt_r + CCM_PER_STEP == ctl_r.period_count) begin
            result_nxt = (acc_sum > CCM_ACC_W'(CCM_RES_MAX)) ? CCM_RES_MAX : acc_sum[15:0];
            acc_nxt    = '0;
            cnt_nxt    = '0;
            if (ctl_r.single_shot) begin
              mstate_nxt = CCM_M_HOLD;
            end  // otherwise the next period starts at once
          end else begin
            acc_nxt = acc_sum;
            cnt_nxt = cnt_r + CCM_PER_STEP;
          end
        end
      end
      CCM_M_HOLD: begin
        if (!ctl_r.enable) begin  // restart needs enable low then high
          mstate_nxt = CCM_M_IDLE;
        end
      end
      default: mstate_nxt = CCM_M_IDLE;
    endcase
    busy_nxt = (mstate_nxt == CCM_M_RUN);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mstate_r <= CCM_M_IDLE;
      acc_r    <= '0;
      cnt_r    <= CCM_PER_RST;
      result_r <= CCM_RES_RST;
      busy_r   <= 1'b0;
    end else begin
      mstate_r <= mstate_nxt;
      acc_r    <= acc_nxt;
      cnt_r    <= cnt_nxt;
      result_r <= result_nxt;
      busy_r   <= busy_nxt;
    end
  end

  assign rd_valid_out                = rd_valid_r;
  assign rd_data_out                 = rd_data_r;
  assign conf_out                    = '{party_b_tx: slot_b_tx,
                                         party_b_rx: slot_b_rx,
                                         party_c_tx: slot_c_tx,
                                         party_c_rx: slot_c_rx,
                                         party_d_tx: slot_d_tx,
                                         party_d_rx: slot_d_rx};
  assign meter_ctl_out               = ctl_r;
  assign meter_result_out            = result_r;
  assign meter_busy_out              = busy_r;
  assign callerid_flag_bit_count_out = flag_len_r;

endmodule // ccm_regs

// one conference slot and highway register, written by its own command code
module ccm_slot_reg
  import ccm_pkg::*;
#(
  parameter logic [6:0] WR_CODE = CCM_CODE_B_TX
)
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_valid_in,
  input  wire logic [6:0] wr_code_in,
  input  wire logic [7:0] wr_data_in,
  output ccm_slot_t       slot_out
);

  ccm_slot_t slot_r, slot_nxt;

  always_comb begin
    slot_nxt = slot_r;
    if (wr_valid_in && (wr_code_in == WR_CODE)) begin
      slot_nxt = ccm_slot_t'(wr_data_in);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_r <= CCM_SLOT_RST;
    end else begin
      slot_r <= slot_nxt;
    end
  end

  assign slot_out = slot_r;

endmodule // ccm_slot_reg

/* verification/ccm_host.sv */
// host model issuing register command bytes
`timescale 1ns/1ps
module ccm_host (
  input  wire logic       clk_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_byte_out,
  output logic [7:0]      cmd_wdata_out
);
  initial cmd_valid_out = 1'b0;
  initial cmd_byte_out = 8'h00;
  initial cmd_wdata_out = 8'h00;
  // entered at a falling edge; taken at the next rising edge
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic v,
                      output logic [7:0] q);
    cmd_valid_out = 1'b1;
    cmd_byte_out = c;
    cmd_wdata_out = d;
    @(negedge clk_in);
    v = rd_valid_in;
    q = rd_data_in;
  endtask
  // released lines toggle so stale values never pose as a command
  task automatic idle();
    cmd_valid_out = 1'b0;
    cmd_byte_out = ~cmd_byte_out;
    cmd_wdata_out = ~cmd_wdata_out;
  endtask
endmodule // ccm_host

/* verification/ccm_regs_asserts.sv */
// checker for the command port and register write effects
`timescale 1ns/1ps
module ccm_chk
  import ccm_pkg::*;
(
  input wire logic           clk_sys_in,
  input wire logic           rst_n_in,
  input wire logic           cmd_valid_in,
  input wire logic [7:0]     cmd_byte_in,
  input wire logic [7:0]     cmd_wdata_in,
  input wire logic           rd_valid_out,
  input wire logic [7:0]     rd_data_out,
  input wire ccm_conf_t      conf_out,
  input wire ccm_meter_ctl_t meter_ctl_out,
  input wire logic           meter_busy_out,
  input wire logic [7:0]     callerid_flag_bit_count_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  property wp(c, f);
    cmd_valid_in && cmd_byte_in == c |=> f == $past(cmd_wdata_in);
  endproperty
  a_read_answer: assert property (cmd_valid_in && !cmd_byte_in[7] |=> rd_valid_out)
    else $error("read not answered");
  a_write_silent: assert property (cmd_valid_in && cmd_byte_in[7] |=> !rd_valid_out)
    else $error("write answered");
  a_btx_write: assert property (wp(8'hA8, conf_out.party_b_tx))
    else $error("b tx write lost");
  a_brx_write: assert property (wp(8'hA9, conf_out.party_b_rx))
    else $error("b rx write lost");
  a_period_low: assert property (wp(8'hAE, meter_ctl_out.period_count[7:0]))
    else $error("period low write lost");
  a_flag_write: assert property (wp(8'hB2, callerid_flag_bit_count_out))
    else $error("flag length write lost");
  a_ctl_write: assert property (cmd_valid_in && cmd_byte_in == 8'hAF |=>
    {meter_ctl_out[14:11], meter_ctl_out[10:8]} == {$past(cmd_wdata_in[7:4]),
    $past(cmd_wdata_in[2:0])}) else $error("control write lost");
  a_resv_zero: assert property (rd_valid_out && $past(cmd_byte_in) == 8'h2F |->
    !rd_data_out[3]) else $error("reserved bit read as one");
  a_busy_off: assert property (!meter_ctl_out.enable [*2] |-> !meter_busy_out)
    else $error("meter runs while disabled");
  c_read: cover property (rd_valid_out);
  c_run: cover property ($rose(meter_busy_out));
  c_halt: cover property ($fell(meter_busy_out));
endmodule // ccm_chk
bind ccm_regs ccm_chk u_chk (.*);

/* verification/tb.sv */
// testbench: readback, write effects and level meter runs
`timescale 1ns/1ps
module tb;
  import ccm_pkg::*;
  logic             clk, rst_n, cv, fs, rv, busy, gv;
  logic [7:0]       cb, wd, rdat, flag, gd;
  logic [3:0][15:0] pcm;
  logic [15:0]      res;
  ccm_conf_t        conf;
  ccm_meter_ctl_t   mctl;
  int               n_mismatch, tests_run;
  ccm_regs dut (.clk_sys_in(clk), .rst_n_in(rst_n), .cmd_valid_in(cv), .cmd_byte_in(cb),
    .cmd_wdata_in(wd), .frame_strobe_in(fs), .pcm_sample_in(pcm), .rd_valid_out(rv),
    .rd_data_out(rdat), .conf_out(conf), .meter_ctl_out(mctl), .meter_result_out(res),
    .meter_busy_out(busy), .callerid_flag_bit_count_out(flag));
  ccm_host host (.clk_in(clk), .rd_valid_in(rv), .rd_data_in(rdat), .cmd_valid_out(cv),
    .cmd_byte_out(cb), .cmd_wdata_out(wd));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(logic [7:0] c, logic [7:0] d);
    host.xfer(c, d, gv, gd);
    host.idle();
    @(negedge clk);
  endtask
  task automatic rd_chk(logic [7:0] c, logic [7:0] e);
    op(c, 8'h00);
    chk("rd_valid", 16'h0001, {15'h0000, gv});
    chk("rd_data", {8'h00, e}, {8'h00, gd});
  endtask
  task automatic strobe(int n);
    repeat (n) begin
      fs = 1'b1;
      @(negedge clk);
      fs = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic t_conf();
    for (int i = 0; i < 6; i++) host.xfer(8'hA8 + 8'(i), 8'h7F + 8'(i * 64), gv, gd);
    host.idle();
    @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      logic [7:0] v;
      v = 8'h7F + 8'(i * 64);
      chk("conf", {8'h00, v}, {8'h00, conf[47 - 8 * i -: 8]});
      rd_chk(8'h28 + 8'(i), v);
    end
  endtask
  task automatic t_ro();
    op(8'hB0, 8'hFF);
    op(8'hB1, 8'hFF);
    op(8'hB2, 8'hFF);
    chk("flag", 16'h00FF, {8'h00, flag});
    op(8'hAF, 8'h3F);
    rd_chk(8'h2F, 8'h37);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h31, 8'h00);
    chk("chan_sel", 16'h0003, {14'h0000, mctl.channel_select});
    chk("meter_ctl", 16'h1F00, {1'b0, mctl});
  endtask
  task automatic t_meter();
    pcm = {16'h1111, 16'h2222, 16'hFFF0, 16'h4444};
    op(8'hAF, 8'h50);
    strobe(1);
    chk("raw", 16'hFFF0, res);
    op(8'hAF, 8'h10);
    op(8'hAE, 8'h02);
    op(8'hAF, 8'h50);
    strobe(2);
    chk("sum", 16'h0020, res);
    pcm[1] = 16'hFFE0;
    strobe(2);
    chk("repeat", 16'h0040, res);
    rd_chk(8'h30, 8'h40);
    rd_chk(8'h31, 8'h00);
    op(8'hAF, 8'h10);
    pcm[1] = 16'h0030;
    op(8'hAF, 8'hD0);
    strobe(3);
    chk("once", 16'h0060, res);
    chk("busy", 16'h0000, {15'h0000, busy});
    pcm[1] = 16'h0001;
    op(8'hAF, 8'hD0);
    strobe(2);
    chk("hold", 16'h0060, res);
    op(8'hAF, 8'h90);
    op(8'hAF, 8'hD0);
    strobe(2);
    chk("restart", 16'h0002, res);
  endtask
  task automatic t_reset();
    op(8'hA8, 8'hFF);
    op(8'hB2, 8'h33);
    rst_n = 1'b0;
    @(negedge clk);
    chk("conf_rst", 16'h0000, conf[47:32]);
    chk("res_rst", 16'h0000, res);
    chk("flag_rst", 16'h0000, {8'h00, flag});
    chk("ctl_rst", 16'h0000, {1'b0, mctl});
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h28, 8'h00);
    rd_chk(8'h2F, 8'h00);
    rd_chk(8'h32, 8'h00);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    fs = 1'b0;
    pcm = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int c = 'h28; c <= 'h32; c++) rd_chk(8'(c), 8'h00);
    t_conf();
    t_ro();
    t_meter();
    rd_chk(8'h7F, 8'h00);
    t_reset();
    complete_run();
  end
endmodule // tb
